// ---- rtl/iser_pkg.sv ----
// Package: constants for the instrument status and event reporting block.
// Assumes one system clock and a synchronous active-high reset.
package iser_pkg;

  // ----------------------------------------------------------------
  // Status summary byte bit positions
  // ----------------------------------------------------------------
  localparam int SB_OPERATION_SUMMARY_BIT_BIT = 7;
  localparam int SB_RQS_BIT  = 6;
  localparam int SB_ESB_BIT  = 5;
  localparam int SB_RESP_BIT = 4;
  localparam int SB_QUESTIONABLE_SUMMARY_BIT_BIT = 3;
  localparam int SB_ERRQ_BIT = 2;

  // ----------------------------------------------------------------
  // Standard event flag bit positions
  // ----------------------------------------------------------------
  localparam int SE_PON_BIT  = 7;
  localparam int SE_PARSE_BIT = 5;
  localparam int SE_EXEC_BIT = 4;
  localparam int SE_DEV_BIT  = 3;
  localparam int SE_QRY_BIT  = 2;
  localparam int SE_DONE_BIT = 0;

  // Masks: event bits that exist (the others read zero); status bits that may raise service request, all but bit 6
  localparam logic [7:0] SE_USED_MASK = 8'hbd;
  localparam logic [7:0] SB_SRQ_MASK  = 8'hbf;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] BYTE_ZERO      = 8'h00;
  localparam logic [7:0] SELFTEST_PASS  = 8'h00;
  // Command-language version 1991.0: integer part and tenths
  localparam logic [15:0] VERSION_INT   = 16'h07c7;
  localparam logic [3:0]  VERSION_FRAC  = 4'h0;

  // Control modes of the panel
  typedef enum logic [1:0] {
    ISER_LOCAL    = 2'b00,
    ISER_REMOTE   = 2'b01,
    ISER_LOCKOUT  = 2'b10
  } iser_ctl_t;

  // Command execution states
  typedef enum logic [1:0] {
    ISER_IDLE     = 2'b00,
    ISER_WAITING  = 2'b01,
    ISER_TESTING  = 2'b10
  } iser_exec_t;

endpackage : iser_pkg

// ---- rtl/iser_event_reg.sv ----
// Sticky event register with enable mask and summary output.
// Assumes events and clears arrive on sys_clk; set wins over clear.
`timescale 1ns/1ps
module iser_event_reg (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic [7:0] set_bits,
  input  wire logic       clear_all,
  input  wire logic [7:0] enable_mask,
  input  wire logic [7:0] used_mask,
  output logic      [7:0] flags,
  output logic            summary
);

  logic [7:0] next_flags;

  // Set wins over clear, unused bits forced low
  assign next_flags = ((clear_all ? iser_pkg::BYTE_ZERO : flags) | set_bits) & used_mask;
  assign summary    = |(flags & enable_mask);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      flags <= iser_pkg::BYTE_ZERO;
    else
      flags <= next_flags;
  end

endmodule : iser_event_reg

// ---- rtl/iser_status_top.sv ----
// Top: status byte, standard events, control modes, trigger, self-test, wait.
// Assumes a command decoder upstream gives one-cycle command strobes on sys_clk.
// Functional notes
// - Go-to-local returns control to front panel
// - Go-to-remote enters remote control mode
// - Lockout only acts in remote mode
// - Stored power-on choice selects defaults or restore
// - Both trigger commands fire one trigger immediately
// - Self-test returns zero or failure code
// - Wait holds later commands until pending done
// - Version query returns 1991.0
// - Status bit 7: enabled operation event
// - Status bit 6: service request, serial poll
// - Status bit 5: enabled standard event
// - Status bit 4: response data waiting
// - Status bit 3: enabled questionable event
// - Status bit 2: error queue nonempty; 1,0 zero
// - Zero enable bit blocks event from summary
// - Event bit 7: powered on
// - Event bit 5: parse error
// - Event bit 4: execution error
// - Event bit 3: device-specific error
// - Event bit 2: query error or lost output
// - Event bit 0: all done; 6,1 zero
// - Reading questionable register clears it
`timescale 1ns/1ps
module iser_status_top (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Command strobes from the command decoder
  input  wire logic        cmd_local,
  input  wire logic        cmd_remote,
  input  wire logic        panel_lockout_command,
  input  wire logic        powerup_choice_command,
  input  wire logic        powerup_choice_value,
  input  wire logic        cmd_trigger_common,
  input  wire logic        cmd_trigger_immediate,
  input  wire logic        cmd_selftest,
  input  wire logic        cmd_wait,
  input  wire logic        cmd_op_complete,
  input  wire logic        cmd_clear_status,
  input  wire logic        cmd_read_event,
  input  wire logic        cmd_read_questionable_summary_bit,
  input  wire logic        cmd_version,
  // Mask writes
  input  wire logic        event_enable_we,
  input  wire logic        service_enable_we,
  input  wire logic        questionable_summary_bit_enable_we,
  input  wire logic        operation_summary_bit_enable_we,
  input  wire logic [7:0]  mask_wdata,
  // Event sources
  input  wire logic        power_on_event,
  input  wire logic        parse_error,
  input  wire logic        execution_error,
  input  wire logic        device_error,
  input  wire logic        query_empty_read,
  input  wire logic        output_lost,
  input  wire logic [7:0]  questionable_summary_bit_events,
  input  wire logic [7:0]  operation_summary_bit_events,
  input  wire logic        output_queue_nonempty,
  input  wire logic        error_queue_nonempty,
  input  wire logic        pending_ops,
  // Self-test engine
  input  wire logic        selftest_done,
  input  wire logic [7:0]  selftest_code,
  // Status outputs
  output logic      [7:0]  status_summary_byte,
  output logic      [7:0]  standard_event_flags,
  output logic      [7:0]  event_read_data,
  output logic      [7:0]  questionable_summary_bit_read_data,
  output logic      [7:0]  selftest_result,
  output logic             selftest_valid,
  output logic             selftest_start,
  output logic      [15:0] version_int,
  output logic      [3:0]  version_frac,
  output logic             version_valid,
  output logic             service_request,
  output logic             panel_enabled,
  output logic             remote_mode,
  output logic             panel_locked,
  output logic             restore_last_at_powerup,
  output logic             trigger_pulse,
  output logic             cmd_hold
);

  // ----------------------------------------------------------------
  // Control mode
  // ----------------------------------------------------------------
  iser_pkg::iser_ctl_t ctl_mode;
  iser_pkg::iser_ctl_t next_ctl_mode;

  always_comb
  begin
    next_ctl_mode = ctl_mode;
    case (ctl_mode)
      iser_pkg::ISER_LOCAL:
      begin
        if (cmd_remote)
          next_ctl_mode = iser_pkg::ISER_REMOTE;
        // Lockout ignored while local
      end
      iser_pkg::ISER_REMOTE:
      begin
        if (cmd_local)
          next_ctl_mode = iser_pkg::ISER_LOCAL;
        else if (panel_lockout_command)
          next_ctl_mode = iser_pkg::ISER_LOCKOUT;
      end
      iser_pkg::ISER_LOCKOUT:
      begin
        if (cmd_local)
          next_ctl_mode = iser_pkg::ISER_LOCAL;
        else if (cmd_remote)
          next_ctl_mode = iser_pkg::ISER_REMOTE;
      end
      default:
        next_ctl_mode = iser_pkg::ISER_LOCAL;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      ctl_mode <= iser_pkg::ISER_LOCAL;
    else
      ctl_mode <= next_ctl_mode;
  end

  assign panel_enabled = (ctl_mode == iser_pkg::ISER_LOCAL);
  assign remote_mode   = (ctl_mode != iser_pkg::ISER_LOCAL);
  assign panel_locked  = (ctl_mode == iser_pkg::ISER_LOCKOUT);

  // ----------------------------------------------------------------
  // Power-on choice
  // ----------------------------------------------------------------
  // Kept in nonvolatile store in a real part; here it survives only until srst
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      restore_last_at_powerup <= 1'b0;
    else if (powerup_choice_command)
      restore_last_at_powerup <= powerup_choice_value;
  end

  // ----------------------------------------------------------------
  // Trigger
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      trigger_pulse <= 1'b0;
    else
      trigger_pulse <= cmd_trigger_common | cmd_trigger_immediate;
  end

  // ----------------------------------------------------------------
  // Wait and self-test sequencing
  // ----------------------------------------------------------------
  iser_pkg::iser_exec_t exec_state;
  iser_pkg::iser_exec_t next_exec_state;
  logic                 opc_armed;
  logic                 done_event;

  always_comb
  begin
    next_exec_state = exec_state;
    case (exec_state)
      iser_pkg::ISER_IDLE:
      begin
        if (cmd_wait && pending_ops)
          next_exec_state = iser_pkg::ISER_WAITING;
        else if (cmd_selftest)
          next_exec_state = iser_pkg::ISER_TESTING;
      end
      iser_pkg::ISER_WAITING:
      begin
        if (!pending_ops)
          next_exec_state = iser_pkg::ISER_IDLE;
      end
      iser_pkg::ISER_TESTING:
      begin
        if (selftest_done)
          next_exec_state = iser_pkg::ISER_IDLE;
      end
      default:
        next_exec_state = iser_pkg::ISER_IDLE;
    endcase
  end

  // Holding off the decoder also covers the self-test run
  assign cmd_hold       = (exec_state != iser_pkg::ISER_IDLE);
  assign selftest_start = (exec_state == iser_pkg::ISER_IDLE) && cmd_selftest
                          && !(cmd_wait && pending_ops);
  assign done_event     = opc_armed && !pending_ops;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      exec_state <= iser_pkg::ISER_IDLE;
    else
      exec_state <= next_exec_state;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      opc_armed <= 1'b0;
    else if (cmd_op_complete)
      opc_armed <= 1'b1;
    else if (done_event)
      opc_armed <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      selftest_result <= iser_pkg::SELFTEST_PASS;
      selftest_valid  <= 1'b0;
    end
    else if (exec_state == iser_pkg::ISER_TESTING && selftest_done)
    begin
      selftest_result <= selftest_code;
      selftest_valid  <= 1'b1;
    end
    else
      selftest_valid  <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Version
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      version_int   <= iser_pkg::VERSION_INT;
      version_frac  <= iser_pkg::VERSION_FRAC;
      version_valid <= 1'b0;
    end
    else
    begin
      version_int   <= iser_pkg::VERSION_INT;
      version_frac  <= iser_pkg::VERSION_FRAC;
      version_valid <= cmd_version;
    end
  end

  // ----------------------------------------------------------------
  // Enable masks
  // ----------------------------------------------------------------
  logic [7:0] event_enable;
  logic [7:0] service_enable;
  logic [7:0] questionable_summary_bit_enable;
  logic [7:0] operation_summary_bit_enable;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      event_enable   <= iser_pkg::BYTE_ZERO;
      service_enable <= iser_pkg::BYTE_ZERO;
      questionable_summary_bit_enable    <= iser_pkg::BYTE_ZERO;
      operation_summary_bit_enable    <= iser_pkg::BYTE_ZERO;
    end
    else
    begin
      if (event_enable_we)
        event_enable <= mask_wdata;
      if (service_enable_we)
        service_enable <= mask_wdata;
      if (questionable_summary_bit_enable_we)
        questionable_summary_bit_enable <= mask_wdata;
      if (operation_summary_bit_enable_we)
        operation_summary_bit_enable <= mask_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Standard event flags
  // ----------------------------------------------------------------
  logic [7:0] std_set;
  logic       std_summary;
  logic       std_clear;

  assign std_set[iser_pkg::SE_PON_BIT]   = power_on_event;
  assign std_set[6]                      = 1'b0;
  assign std_set[iser_pkg::SE_PARSE_BIT] = parse_error;
  assign std_set[iser_pkg::SE_EXEC_BIT]  = execution_error;
  assign std_set[iser_pkg::SE_DEV_BIT]   = device_error;
  assign std_set[iser_pkg::SE_QRY_BIT]   = query_empty_read | output_lost;
  assign std_set[1]                      = 1'b0;
  assign std_set[iser_pkg::SE_DONE_BIT]  = done_event;
  assign std_clear = cmd_read_event | cmd_clear_status;

  iser_event_reg u_std_events (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .set_bits    (std_set),
    .clear_all   (std_clear),
    .enable_mask (event_enable),
    .used_mask   (iser_pkg::SE_USED_MASK),
    .flags       (standard_event_flags),
    .summary     (std_summary)
  );

  // ----------------------------------------------------------------
  // Questionable and operation events
  // ----------------------------------------------------------------
  logic [7:0] questionable_summary_bit_flags;
  logic       questionable_summary_bit_summary;
  logic [7:0] operation_summary_bit_flags;
  logic       operation_summary_bit_summary;

  iser_event_reg u_questionable_summary_bit_events (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .set_bits    (questionable_summary_bit_events),
    .clear_all   (cmd_read_questionable_summary_bit | cmd_clear_status),
    .enable_mask (questionable_summary_bit_enable),
    .used_mask   (8'hff),
    .flags       (questionable_summary_bit_flags),
    .summary     (questionable_summary_bit_summary)
  );

  iser_event_reg u_operation_summary_bit_events (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .set_bits    (operation_summary_bit_events),
    .clear_all   (cmd_clear_status),
    .enable_mask (operation_summary_bit_enable),
    .used_mask   (8'hff),
    .flags       (operation_summary_bit_flags),
    .summary     (operation_summary_bit_summary)
  );

  // Snapshots taken before the clear so the read sees the old contents
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      questionable_summary_bit_read_data  <= iser_pkg::BYTE_ZERO;
      event_read_data <= iser_pkg::BYTE_ZERO;
    end
    else
    begin
      if (cmd_read_questionable_summary_bit)
        questionable_summary_bit_read_data <= questionable_summary_bit_flags;
      if (cmd_read_event)
        event_read_data <= standard_event_flags;
    end
  end

  // ----------------------------------------------------------------
  // Status summary byte and service request
  // ----------------------------------------------------------------
  logic [7:0] sb_base;

  assign sb_base[iser_pkg::SB_OPERATION_SUMMARY_BIT_BIT] = operation_summary_bit_summary;
  assign sb_base[iser_pkg::SB_RQS_BIT]  = 1'b0;
  assign sb_base[iser_pkg::SB_ESB_BIT]  = std_summary;
  assign sb_base[iser_pkg::SB_RESP_BIT] = output_queue_nonempty;
  assign sb_base[iser_pkg::SB_QUESTIONABLE_SUMMARY_BIT_BIT] = questionable_summary_bit_summary;
  assign sb_base[iser_pkg::SB_ERRQ_BIT] = error_queue_nonempty;
  assign sb_base[1:0]                   = 2'b00;

  assign service_request = |(sb_base & service_enable & iser_pkg::SB_SRQ_MASK);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      status_summary_byte <= iser_pkg::BYTE_ZERO;
    else
    begin
      status_summary_byte                       <= sb_base;
      status_summary_byte[iser_pkg::SB_RQS_BIT] <= service_request;
    end
  end

endmodule : iser_status_top

// ---- tb/iser_selftest_model.sv ----
// Self-test engine model: answers each start with done after LAT cycles.
// Assumes start is a one-cycle pulse on sys_clk.
`timescale 1ns/1ps
module iser_selftest_model #(
  parameter int LAT = 5
) (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       selftest_start,
  input  wire logic [7:0] fail_code,
  output logic            selftest_done,
  output logic      [7:0] selftest_code
);
  int cnt;

  always_ff @(posedge sys_clk)
  begin
    selftest_done <= 1'b0;
    // Code is junk outside done, so a stale read shows
    selftest_code <= ~selftest_code;
    if (srst)
    begin
      cnt           <= 0;
      selftest_code <= 8'h00;
    end
    else if (selftest_start)
      cnt <= LAT;
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      if (cnt == 1)
      begin
        selftest_done <= 1'b1;
        selftest_code <= fail_code;
      end
    end
  end
endmodule : iser_selftest_model

// ---- tb/iser_status_properties.sv ----
// Checker for the status and event block, bound to its top ports.
// Assumes one clock domain and synchronous reset.
`timescale 1ns/1ps
module iser_status_props (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        cmd_local,
  input wire logic        cmd_remote,
  input wire logic        panel_lockout_command,
  input wire logic        cmd_trigger_common,
  input wire logic        cmd_trigger_immediate,
  input wire logic        cmd_wait,
  input wire logic        cmd_version,
  input wire logic        parse_error,
  input wire logic        output_queue_nonempty,
  input wire logic        pending_ops,
  input wire logic [7:0]  status_summary_byte,
  input wire logic [7:0]  standard_event_flags,
  input wire logic [15:0] version_int,
  input wire logic        version_valid,
  input wire logic        trigger_pulse,
  input wire logic        panel_enabled,
  input wire logic        panel_locked,
  input wire logic        cmd_hold
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_local; cmd_local |=> panel_enabled && !panel_locked; endproperty
  a_local: assert property (p_local) else $error("local not taken");
  property p_remote; cmd_remote && !cmd_local |=> !panel_enabled; endproperty
  a_remote: assert property (p_remote) else $error("remote not taken");
  property p_lock_idle;
    panel_lockout_command && panel_enabled && !cmd_remote |=> panel_enabled && !panel_locked;
  endproperty
  a_lock_idle: assert property (p_lock_idle) else $error("lockout acted in local");
  property p_lock;
    panel_lockout_command && !panel_enabled && !cmd_local && !cmd_remote |=> panel_locked;
  endproperty
  a_lock: assert property (p_lock) else $error("lockout not taken");
  property p_trig; cmd_trigger_common || cmd_trigger_immediate |=> trigger_pulse; endproperty
  a_trig: assert property (p_trig) else $error("no trigger pulse");
  property p_trig_once;
    trigger_pulse && !cmd_trigger_common && !cmd_trigger_immediate |=> !trigger_pulse;
  endproperty
  a_trig_once: assert property (p_trig_once) else $error("trigger too long");
  property p_parse; parse_error |=> standard_event_flags[5]; endproperty
  a_parse: assert property (p_parse) else $error("parse flag missing");
  property p_unused;
    standard_event_flags[6] == 1'b0 && standard_event_flags[1] == 1'b0
      && status_summary_byte[1:0] == 2'b00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");
  property p_resp; 1'b1 |=> status_summary_byte[4] == $past(output_queue_nonempty); endproperty
  a_resp: assert property (p_resp) else $error("response bit wrong");
  property p_ver; cmd_version |=> version_valid && version_int == 16'h07c7; endproperty
  a_ver: assert property (p_ver) else $error("version answer wrong");
  property p_wait; cmd_wait && pending_ops && !cmd_hold |=> cmd_hold; endproperty
  a_wait: assert property (p_wait) else $error("wait did not hold");

  c_wait: cover property (cmd_wait && pending_ops);
  c_lock: cover property (panel_lockout_command && !panel_enabled);
  c_esb: cover property (status_summary_byte[5]);
endmodule : iser_status_props

bind iser_status_top iser_status_props u_props (
  .sys_clk, .srst, .cmd_local, .cmd_remote, .panel_lockout_command, .cmd_trigger_common,
  .cmd_trigger_immediate, .cmd_wait, .cmd_version, .parse_error, .output_queue_nonempty,
  .pending_ops, .status_summary_byte, .standard_event_flags, .version_int, .version_valid,
  .trigger_pulse, .panel_enabled, .panel_locked, .cmd_hold
);

// ---- tb/iser_status_top_tb.sv ----
// Bench for the status block: command strobes and checked answers.
// Assumes the self-test engine model and the bound checker.
`timescale 1ns/1ps
module iser_status_top_tb;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic [22:0] st = '0;
  logic [7:0]  mwd = '0, qev = '0, oev = '0, fcode = '0;
  logic        pchv = 1'b0, oq = 1'b0, eq = 1'b0, pend = 1'b0;
  logic [7:0]  sb, sef, erd, qrd, str, code;
  logic [15:0] vint;
  logic [3:0]  vfrac;
  logic        stv, sts, vv, srq, pen, rem, lck, rlast, trg, hold, done;
  logic [7:0]  exp_ev [6] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h04, 8'h04};
  int          failures = 0, n_tests = 0, k;

  always #12.5 sys_clk = ~sys_clk;

  iser_status_top uut (
    .sys_clk, .srst, .cmd_local(st[0]), .cmd_remote(st[1]), .panel_lockout_command(st[2]),
    .powerup_choice_command(st[3]), .powerup_choice_value(pchv), .cmd_trigger_common(st[4]),
    .cmd_trigger_immediate(st[5]), .cmd_selftest(st[6]), .cmd_wait(st[7]),
    .cmd_op_complete(st[8]), .cmd_clear_status(st[9]), .cmd_read_event(st[10]),
    .cmd_read_questionable_summary_bit(st[11]), .cmd_version(st[12]), .event_enable_we(st[13]),
    .service_enable_we(st[14]), .questionable_summary_bit_enable_we(st[15]), .operation_summary_bit_enable_we(st[16]),
    .mask_wdata(mwd), .power_on_event(st[17]), .parse_error(st[18]),
    .execution_error(st[19]), .device_error(st[20]), .query_empty_read(st[21]),
    .output_lost(st[22]), .questionable_summary_bit_events(qev), .operation_summary_bit_events(oev), .output_queue_nonempty(oq),
    .error_queue_nonempty(eq), .pending_ops(pend), .selftest_done(done),
    .selftest_code(code), .status_summary_byte(sb), .standard_event_flags(sef),
    .event_read_data(erd), .questionable_summary_bit_read_data(qrd), .selftest_result(str),
    .selftest_valid(stv), .selftest_start(sts), .version_int(vint), .version_frac(vfrac),
    .version_valid(vv), .service_request(srq), .panel_enabled(pen), .remote_mode(rem),
    .panel_locked(lck), .restore_last_at_powerup(rlast), .trigger_pulse(trg),
    .cmd_hold(hold)
  );

  iser_selftest_model #(.LAT(5)) u_eng (
    .sys_clk, .srst, .selftest_start(sts), .fail_code(fcode), .selftest_done(done),
    .selftest_code(code)
  );

  // ------------------------------
  // Access tasks
  // ------------------------------
  // Wide enough for the version word with its fraction
  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic send(input int i, input logic [7:0] v = 8'h00);
    @(posedge sys_clk);
    st[i] <= 1'b1;
    mwd   <= v;
    @(posedge sys_clk);
    st[i] <= 1'b0;
    #1;
  endtask : send

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic vpulse(input logic [7:0] q, input logic [7:0] o);
    @(posedge sys_clk);
    qev <= q;
    oev <= o;
    @(posedge sys_clk);
    qev <= 8'h00;
    oev <= 8'h00;
  endtask : vpulse

  task automatic wrap_up;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  // Bounded waits end here when their limit runs out
  task automatic tmo(input int lim);
    if (k >= lim)
    begin
      failures++;
      $display("unexpected wait: expected %0d seen %0d", lim - 1, k);
      wrap_up();
    end
  endtask : tmo

  // ------------------------------
  // Scenarios
  // ------------------------------
  initial
  begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    #1;
    chk("status", 8'h00, sb);
    chk("panel", 1'b1, pen);
    chk("restore", 1'b0, rlast);
    $display("reset test done");
    send(2);
    chk("locked", 1'b0, lck);
    send(1);
    chk("remote", 1'b1, rem);
    chk("panel", 1'b0, pen);
    send(2);
    chk("locked", 1'b1, lck);
    send(0);
    chk("panel", 1'b1, pen);
    chk("locked", 1'b0, lck);
    pchv <= 1'b1;
    send(3);
    chk("restore", 1'b1, rlast);
    pchv <= 1'b0;
    send(3);
    chk("restore", 1'b0, rlast);
    for (int i = 4; i < 6; i++)
    begin
      send(i);
      chk("trigger", 1'b1, trg);
      tick(1);
      chk("trigger", 1'b0, trg);
    end
    send(12);
    chk("version", 20'h07c70, {vint, vfrac});
    chk("version valid", 1'b1, vv);
    $display("control test done");
    send(13, 8'hff);
    for (int i = 0; i < 6; i++)
    begin
      send(17 + i);
      chk("flags", exp_ev[i], sef);
      tick(1);
      chk("esb", 1'b1, sb[5]);
      send(10);
      chk("event read", exp_ev[i], erd);
      chk("flags", 8'h00, sef);
    end
    send(13, 8'hdf);
    send(18);
    tick(1);
    chk("esb", 1'b0, sb[5]);
    send(9);
    chk("flags", 8'h00, sef);
    pend <= 1'b1;
    send(8);
    tick(2);
    chk("done flag", 1'b0, sef[0]);
    pend <= 1'b0;
    for (k = 0; k < 8 && sef[0] !== 1'b1; k++) tick(1);
    tmo(8);
    chk("done flag", 1'b1, sef[0]);
    pend <= 1'b1;
    send(7);
    chk("hold", 1'b1, hold);
    tick(3);
    chk("hold", 1'b1, hold);
    pend <= 1'b0;
    for (k = 0; k < 4 && hold !== 1'b0; k++) tick(1);
    tmo(4);
    $display("event test done");
    send(15, 8'hff);
    vpulse(8'h05, 8'h00);
    tick(1);
    chk("questionable_summary_bit sum", 1'b1, sb[3]);
    send(11);
    chk("questionable_summary_bit read", 8'h05, qrd);
    send(11);
    chk("questionable_summary_bit read", 8'h00, qrd);
    send(16, 8'h02);
    vpulse(8'h00, 8'h01);
    tick(1);
    chk("operation_summary_bit sum", 1'b0, sb[7]);
    vpulse(8'h00, 8'h02);
    tick(1);
    chk("operation_summary_bit sum", 1'b1, sb[7]);
    @(posedge sys_clk);
    oq <= 1'b1;
    eq <= 1'b1;
    tick(1);
    chk("levels", 3'h4, {sb[4], sb[1:0]});
    chk("errq", 1'b1, sb[2]);
    send(14, 8'h10);
    for (k = 0; k < 4 && sb[6] !== 1'b1; k++) tick(1);
    tmo(4);
    chk("srq", 1'b1, srq);
    send(14, 8'h40);
    tick(2);
    chk("srq", 1'b0, srq);
    $display("summary test done");
    for (int i = 0; i < 2; i++)
    begin
      fcode <= i ? 8'h2a : 8'h00;
      send(6);
      for (k = 0; k < 12 && stv !== 1'b1; k++) tick(1);
      tmo(12);
      chk("selftest", i ? 8'h2a : 8'h00, str);
    end
    $display("selftest test done");
    wrap_up();
  end
endmodule : iser_status_top_tb
